// ==== shared/ppgc_pkg.sv ====
// ppgc_pkg: register map, field positions and reset values of the pulse generator control slice
package ppgc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_MODE = 12'h004;
    localparam logic [11:0] OFF_STAT = 12'h008;

    ////////////////////////////////////////////////////////////////////////////
    // trigger_irq_output_control fields
    localparam int CTRL_STOP_EDGE_EN_BIT = 7;
    localparam int CTRL_START_EDGE_EN_BIT = 6;
    localparam int CTRL_IRQ_EN_BIT = 5;
    localparam int CTRL_IRQ_FLAG_BIT = 4;
    localparam int CTRL_IRQ_SRC_LSB = 2;
    localparam int CTRL_PIN_OE_BIT = 1;
    localparam int CTRL_POLARITY_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // timer_mode_control fields
    localparam int MODE_TIMER_EN_BIT = 7;
    localparam int MODE_SOFT_TRIG_BIT = 6;
    localparam int MODE_ONE_SHOT_BIT = 5;
    localparam int MODE_RETRIG_EN_BIT = 4;
    localparam int MODE_CLK_SEL_LSB = 1;
    localparam int MODE_MASK_EN_BIT = 0;
    localparam logic [7:0] MODE_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt source codes
    localparam logic [1:0] SRC_TRIGGER = 2'h0;
    localparam logic [1:0] SRC_BORROW = 2'h1;
    localparam logic [1:0] SRC_EDGE = 2'h2;
    localparam logic [1:0] SRC_BORROW_EDGE = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // ahb-lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;

endpackage : ppgc_pkg

// ==== verilog/ppgc_trig_sync.sv ====
// ppgc_trig_sync: two-stage synchroniser and edge detector for the hardware trigger input
`timescale 1ns/100ps
module ppgc_trig_sync (
    input wire logic mclk_in,     // operating clock
    input wire logic rst_n_in,    // synchronous reset, active low
    input wire logic trig_in,     // raw trigger level
    output logic rise_out,        // one-cycle pulse on rising edge
    output logic fall_out         // one-cycle pulse on falling edge
);

    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // first stage feeds only the second stage
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
            rise_out <= 1'b0;
            fall_out <= 1'b0;
        end else begin
            meta_reg <= trig_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
            rise_out <= sync_reg & ~last_reg;
            fall_out <= ~sync_reg & last_reg;
        end
    end

endmodule : ppgc_trig_sync

// ==== verilog/ppgc_ahb_front.sv ====
// ppgc_ahb_front: ahb-lite address phase capture for the register slave
`timescale 1ns/100ps
module ppgc_ahb_front (
    input wire logic mclk_in,            // operating clock
    input wire logic rst_n_in,           // synchronous reset, active low
    input wire logic hsel_in,            // slave select
    input wire logic [11:0] haddr_in,    // byte address
    input wire logic [1:0] htrans_in,    // transfer type
    input wire logic hwrite_in,          // write when high
    input wire logic hready_in,          // bus ready
    output logic rd_req_out,             // read taken this cycle (comb)
    output logic wr_valid_out,           // write data phase now
    output logic [11:0] wr_addr_out      // address of the pending write
);

    logic take;

    always_comb begin
        take = hsel_in && hready_in &&
               (htrans_in == ppgc_pkg::HTRANS_NONSEQ || htrans_in == ppgc_pkg::HTRANS_SEQ);
        rd_req_out = take && !hwrite_in;
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            wr_valid_out <= 1'b0;
            wr_addr_out <= 12'h000;
        end else begin
            wr_valid_out <= take && hwrite_in;
            if (take) begin
                wr_addr_out <= haddr_in;
            end
        end
    end

endmodule : ppgc_ahb_front

// ==== verilog/ppgc_top.sv ====
// ppgc_top: trigger, interrupt and output control of one 16-bit pulse generator channel
`timescale 1ns/100ps
module ppgc_top #(
    parameter int COUNT_WIDTH = 16  // width of cycle and duty values
) (
    input wire logic mclk_in,                       // operating clock
    input wire logic rst_n_in,                      // synchronous reset, active low
    input wire logic hsel_in,                       // ahb slave select
    input wire logic [11:0] haddr_in,               // ahb byte address
    input wire logic [1:0] htrans_in,               // ahb transfer type
    input wire logic hwrite_in,                     // ahb write
    input wire logic [2:0] hsize_in,                // ahb size, word only
    input wire logic hmastlock_in,                  // locked (rmw) transfer
    input wire logic hready_in,                     // ahb bus ready
    input wire logic [31:0] hwdata_in,              // ahb write data
    output logic [31:0] hrdata_out,                 // ahb read data
    output logic hreadyout_out,                     // ahb slave ready
    output logic hresp_out,                         // ahb response, always okay
    input wire logic hw_trigger_input_in,           // external trigger pin level
    input wire logic count_tick_in,                 // prescaled count clock tick
    input wire logic borrow_in,                     // down-counter borrow pulse
    input wire logic duty_match_in,                 // counter equals duty pulse
    input wire logic [COUNT_WIDTH-1:0] cycle_in,    // active cycle value
    input wire logic [COUNT_WIDTH-1:0] duty_in,     // active duty value
    input wire logic port_data_in,                  // general-purpose port level
    output logic counter_load_out,                  // pulse: load counter, start
    output logic counter_run_out,                   // counter may count
    output logic [2:0] clock_select_out,            // prescaler selection
    output logic pulse_output_pin_out,              // pin level
    output logic pin_output_enable_out,             // pin owned by generator
    output logic irq_out                            // interrupt request level
);

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [2:0] {
        ST_STOP = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN = 3'b100
    } ppgc_run_e;

    typedef struct packed {
        ppgc_run_e st;
        logic stop_edge_enable;
        logic start_edge_enable;
        logic irq_enable;
        logic irq_flag;
        logic [1:0] irq_source_select;
        logic pin_output_enable;
        logic output_polarity_select;
        logic timer_enable;
        logic one_shot;
        logic soft_retrigger_enable;
        logic [2:0] clk_sel;
        logic output_mask_enable;
        logic wave;
        logic retrig_low;
        logic duty_irq_done;
        logic load;
        logic irq;
        logic pin;
        logic [31:0] rdata;
    } ppgc_state_s;

    localparam ppgc_state_s RESET_STATE = '{st: ST_STOP, default: '0};

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [7:0] ppgc_ctrl_byte(input ppgc_state_s s, input logic rmw);
        logic [7:0] b;
        b = ppgc_pkg::CTRL_RESET;
        b[ppgc_pkg::CTRL_STOP_EDGE_EN_BIT] = s.stop_edge_enable;
        b[ppgc_pkg::CTRL_START_EDGE_EN_BIT] = s.start_edge_enable;
        b[ppgc_pkg::CTRL_IRQ_EN_BIT] = s.irq_enable;
        b[ppgc_pkg::CTRL_IRQ_FLAG_BIT] = s.irq_flag | rmw;
        b[ppgc_pkg::CTRL_IRQ_SRC_LSB +: 2] = s.irq_source_select;
        b[ppgc_pkg::CTRL_PIN_OE_BIT] = s.pin_output_enable;
        b[ppgc_pkg::CTRL_POLARITY_BIT] = s.output_polarity_select;
        return b;
    endfunction : ppgc_ctrl_byte

    function automatic logic [7:0] ppgc_mode_byte(input ppgc_state_s s);
        logic [7:0] b;
        b = ppgc_pkg::MODE_RESET;
        b[ppgc_pkg::MODE_TIMER_EN_BIT] = s.timer_enable;
        b[ppgc_pkg::MODE_SOFT_TRIG_BIT] = 1'b0;
        b[ppgc_pkg::MODE_ONE_SHOT_BIT] = s.one_shot;
        b[ppgc_pkg::MODE_RETRIG_EN_BIT] = s.soft_retrigger_enable;
        b[ppgc_pkg::MODE_CLK_SEL_LSB +: 3] = s.clk_sel;
        b[ppgc_pkg::MODE_MASK_EN_BIT] = s.output_mask_enable;
        return b;
    endfunction : ppgc_mode_byte

    ////////////////////////////////////////////////////////////////////////////
    // submodules
    logic trig_rise;
    logic trig_fall;
    logic rd_req;
    logic wr_valid;
    logic [11:0] wr_addr;

    ppgc_trig_sync u_sync (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .trig_in(hw_trigger_input_in),
        .rise_out(trig_rise),
        .fall_out(trig_fall)
    );

    ppgc_ahb_front u_front (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .hsel_in(hsel_in),
        .haddr_in(haddr_in),
        .htrans_in(htrans_in),
        .hwrite_in(hwrite_in),
        .hready_in(hready_in),
        .rd_req_out(rd_req),
        .wr_valid_out(wr_valid),
        .wr_addr_out(wr_addr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state
    ppgc_state_s r;
    ppgc_state_s n;
    logic soft_trig;
    logic start_evt;
    logic trig_evt;
    logic borrow_evt;
    logic edge_evt;
    logic src_evt;
    logic equal_cd;
    logic duty_valid;
    logic idle_lvl;
    logic run_lvl;

    always_comb begin
        n = r;
        n.load = 1'b0;
        soft_trig = 1'b0;
        trig_evt = 1'b0;
        borrow_evt = 1'b0;
        equal_cd = (cycle_in == duty_in);
        duty_valid = (duty_in != '0) && (duty_in <= cycle_in);

        // register writes, data phase
        if (wr_valid) begin
            if (wr_addr == ppgc_pkg::OFF_CTRL) begin
                n.stop_edge_enable = hwdata_in[ppgc_pkg::CTRL_STOP_EDGE_EN_BIT];
                n.start_edge_enable = hwdata_in[ppgc_pkg::CTRL_START_EDGE_EN_BIT];
                n.irq_enable = hwdata_in[ppgc_pkg::CTRL_IRQ_EN_BIT];
                if (!hwdata_in[ppgc_pkg::CTRL_IRQ_FLAG_BIT]) begin
                    n.irq_flag = 1'b0;
                end
                n.irq_source_select = hwdata_in[ppgc_pkg::CTRL_IRQ_SRC_LSB +: 2];
                n.pin_output_enable = hwdata_in[ppgc_pkg::CTRL_PIN_OE_BIT];
                n.output_polarity_select = hwdata_in[ppgc_pkg::CTRL_POLARITY_BIT];
            end else if (wr_addr == ppgc_pkg::OFF_MODE) begin
                n.timer_enable = hwdata_in[ppgc_pkg::MODE_TIMER_EN_BIT];
                soft_trig = hwdata_in[ppgc_pkg::MODE_SOFT_TRIG_BIT];
                n.one_shot = hwdata_in[ppgc_pkg::MODE_ONE_SHOT_BIT];
                n.soft_retrigger_enable = hwdata_in[ppgc_pkg::MODE_RETRIG_EN_BIT];
                n.clk_sel = hwdata_in[ppgc_pkg::MODE_CLK_SEL_LSB +: 3];
                n.output_mask_enable = hwdata_in[ppgc_pkg::MODE_MASK_EN_BIT];
            end
        end

        // start request from software or enabled rising edge
        start_evt = (soft_trig && n.timer_enable) ||
                    (trig_rise && n.start_edge_enable);

        // run control
        if (!n.timer_enable) begin
            n.st = ST_STOP;
            n.wave = 1'b0;
            n.retrig_low = 1'b0;
        end else begin
            case (r.st)
                ST_STOP, ST_WAIT: begin
                    n.st = ST_WAIT;
                    if (start_evt) begin
                        n.st = ST_RUN;
                        n.load = 1'b1;
                        n.wave = 1'b0;
                        n.retrig_low = 1'b0;
                        n.duty_irq_done = 1'b0;
                        trig_evt = 1'b1;
                    end
                end
                ST_RUN: begin
                    if (trig_fall && n.stop_edge_enable) begin
                        n.st = ST_WAIT;
                        n.wave = 1'b0;
                        n.retrig_low = 1'b0;
                    end else if (start_evt && (n.soft_retrigger_enable || !soft_trig)) begin
                        n.load = 1'b1;
                        n.wave = 1'b0;
                        n.retrig_low = equal_cd;
                        trig_evt = 1'b1;
                    end else begin
                        if (r.retrig_low && count_tick_in) begin
                            n.wave = 1'b1;
                            n.retrig_low = 1'b0;
                        end
                        if (duty_match_in && duty_valid) begin
                            n.wave = 1'b1;
                        end
                        if (borrow_in) begin
                            borrow_evt = 1'b1;
                            if (!equal_cd) begin
                                n.wave = 1'b0;
                            end
                            if (n.one_shot) begin
                                n.st = ST_WAIT;
                                n.wave = 1'b0;
                            end
                        end
                    end
                end
                default: begin
                    n.st = ST_STOP;
                end
            endcase
        end

        // rising internal wave is the active pin edge in either polarity
        edge_evt = n.wave && !r.wave && !(equal_cd && r.duty_irq_done);
        if (edge_evt && equal_cd) begin
            n.duty_irq_done = 1'b1;
        end

        // interrupt source selection
        case (n.irq_source_select)
            ppgc_pkg::SRC_TRIGGER: src_evt = trig_evt;
            ppgc_pkg::SRC_BORROW: src_evt = borrow_evt;
            ppgc_pkg::SRC_EDGE: src_evt = edge_evt;
            default: src_evt = borrow_evt || edge_evt;
        endcase
        if (src_evt) begin
            n.irq_flag = 1'b1;
        end
        n.irq = n.irq_flag && n.irq_enable;

        // pin level
        idle_lvl = n.output_polarity_select;
        run_lvl = (n.st == ST_RUN) && !n.output_mask_enable && n.wave;
        if (n.pin_output_enable) begin
            n.pin = run_lvl ^ idle_lvl;
        end else begin
            n.pin = port_data_in;
        end

        // read data, taken in the address phase from post-write values
        n.rdata = 32'h0000_0000;
        if (rd_req) begin
            if (haddr_in == ppgc_pkg::OFF_CTRL) begin
                n.rdata = {24'h000000, ppgc_ctrl_byte(n, hmastlock_in)};
            end else if (haddr_in == ppgc_pkg::OFF_MODE) begin
                n.rdata = {24'h000000, ppgc_mode_byte(n)};
            end else if (haddr_in == ppgc_pkg::OFF_STAT) begin
                n.rdata = {27'h0000000, n.retrig_low, n.wave, n.st};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            r <= RESET_STATE;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from the state flops; hreadyout_out and hresp_out are constants
    always_comb begin
        hrdata_out = r.rdata;
        hreadyout_out = 1'b1;
        hresp_out = 1'b0;
        counter_load_out = r.load;
        counter_run_out = (r.st == ST_RUN);
        clock_select_out = r.clk_sel;
        pulse_output_pin_out = r.pin;
        pin_output_enable_out = r.pin_output_enable;
        irq_out = r.irq;
    end

endmodule : ppgc_top

// ==== verification/ppgc_chk.sv ====
// ppgc_chk: port-level assertions for the pulse generator control slice
`timescale 1ns/100ps
module ppgc_chk #(
    parameter int COUNT_WIDTH = 16  // count width
) (
    input wire logic mclk_in,  // clock
    input wire logic rst_n_in,  // reset
    input wire logic hsel_in,  // select
    input wire logic [11:0] haddr_in,  // address
    input wire logic [1:0] htrans_in,  // transfer
    input wire logic hwrite_in,  // write
    input wire logic hmastlock_in,  // rmw
    input wire logic hready_in,  // ready
    input wire logic [31:0] hwdata_in,  // wdata
    input wire logic [31:0] hrdata_out,  // rdata
    input wire logic hw_trigger_input_in,  // trigger
    input wire logic borrow_in,  // borrow
    input wire logic duty_match_in,  // match
    input wire logic [COUNT_WIDTH-1:0] cycle_in,  // cycle
    input wire logic [COUNT_WIDTH-1:0] duty_in,  // duty
    input wire logic counter_load_out,  // load
    input wire logic counter_run_out,  // run
    input wire logic pulse_output_pin_out,  // pin
    input wire logic pin_output_enable_out,  // oe
    input wire logic irq_out  // irq
);
    logic ap_wr, ap_rd, ap_lock, pol_sh, start_sh, mask_sh, ten_sh, wr_ctrl, wr_mode, idle_c;
    logic [11:0] ap_addr;
    assign wr_ctrl = ap_wr && (ap_addr == ppgc_pkg::OFF_CTRL);
    assign wr_mode = ap_wr && (ap_addr == ppgc_pkg::OFF_MODE);
    assign idle_c = pin_output_enable_out && (mask_sh || !ten_sh);
    ////////////////////
    // shadow of the bus phase and of the control bits
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            ap_wr <= 1'b0;
            ap_rd <= 1'b0;
            ap_lock <= 1'b0;
            ap_addr <= 12'h000;
            pol_sh <= 1'b0;
            start_sh <= 1'b0;
            mask_sh <= 1'b0;
            ten_sh <= 1'b0;
        end else begin
            if (hready_in) begin
                ap_wr <= hsel_in && htrans_in[1] && hwrite_in;
                ap_rd <= hsel_in && htrans_in[1] && !hwrite_in;
                ap_lock <= hmastlock_in;
                ap_addr <= haddr_in;
            end
            if (wr_ctrl) begin
                pol_sh <= hwdata_in[0];
                start_sh <= hwdata_in[6];
            end
            if (wr_mode) begin
                ten_sh <= hwdata_in[7];
                mask_sh <= hwdata_in[0];
            end
        end
    end
    ////////////////////
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);
    AST_RESET_ZERO: assert property ($rose(rst_n_in) |->
        !irq_out && !pin_output_enable_out && !counter_run_out) else $error("reset");
    AST_PIN_OE: assert property (wr_ctrl |=>
        pin_output_enable_out == $past(hwdata_in[1])) else $error("oe");
    AST_IRQ_GATE: assert property (wr_ctrl && !hwdata_in[5] |=> !irq_out)
        else $error("irq gate");
    AST_RMW_ONE: assert property (ap_rd && ap_lock && ap_addr == ppgc_pkg::OFF_CTRL
        |-> hrdata_out[4]) else $error("rmw");
    AST_SOFT_ZERO: assert property (ap_rd && ap_addr == ppgc_pkg::OFF_MODE
        |-> hrdata_out[6] == 1'b0) else $error("soft");
    AST_STOP_NOW: assert property (wr_mode && !hwdata_in[7] |=> !counter_run_out)
        else $error("stop");
    AST_IDLE_LVL: assert property (idle_c && $past(idle_c) && $past(idle_c, 2) &&
        $stable(pol_sh) && $past(pol_sh, 2) == pol_sh |-> pulse_output_pin_out == pol_sh)
        else $error("idle");
    AST_DUTY_RISE: assert property (duty_match_in && counter_run_out && ten_sh &&
        !mask_sh && pin_output_enable_out && !wr_mode && !wr_ctrl && duty_in != '0 &&
        duty_in <= cycle_in |=> pulse_output_pin_out != pol_sh) else $error("duty");
    AST_BORROW_FALL: assert property (borrow_in && counter_run_out && ten_sh &&
        !mask_sh && pin_output_enable_out && !wr_mode && !wr_ctrl && !duty_match_in &&
        duty_in != cycle_in |=> pulse_output_pin_out == pol_sh) else $error("borrow");
    AST_HW_START: assert property ($rose(hw_trigger_input_in) && start_sh && ten_sh &&
        !counter_run_out |-> ##[2:6] counter_load_out) else $error("hw start");
    AST_LOAD_ONE: assert property (counter_load_out |=> !counter_load_out)
        else $error("load");
endmodule : ppgc_chk

bind ppgc_top ppgc_chk #(.COUNT_WIDTH(COUNT_WIDTH)) u_ppgc_chk (.*);

// ==== verification/ppgc_partner.sv ====
// ppgc_partner: trigger pin driver and down-counter model on the far side
`timescale 1ns/100ps
module ppgc_partner #(
    parameter int COUNT_WIDTH = 16  // count width
) (
    input wire logic mclk_in,  // clock
    input wire logic load_in,  // counter load pulse
    input wire logic run_in,  // counter may count
    input wire logic [COUNT_WIDTH-1:0] cycle_in,  // cycle value
    input wire logic [COUNT_WIDTH-1:0] duty_in,  // duty value
    output logic trig_out,  // trigger pin
    output logic tick_out,  // count tick
    output logic borrow_out,  // borrow pulse
    output logic match_out  // duty match pulse
);
    logic [COUNT_WIDTH-1:0] cnt_reg;
    initial begin
        trig_out = 1'b0;
        tick_out = 1'b0;
        borrow_out = 1'b0;
        match_out = 1'b0;
        cnt_reg = '0;
    end
    // called just after a clock edge
    task automatic drive_trigger(input logic lvl);
        trig_out <= lvl;
    endtask : drive_trigger
    ////////////////////
    // count clock at half rate; match and borrow pulse in the cycle after a tick cycle, with tick low
    always @(posedge mclk_in) begin
        tick_out <= ~tick_out;
        borrow_out <= 1'b0;
        match_out <= 1'b0;
        if (load_in) begin
            cnt_reg <= cycle_in;
        end else if (run_in && tick_out) begin
            borrow_out <= (cnt_reg == '0);
            match_out <= (cnt_reg == duty_in) && (duty_in <= cycle_in);
            cnt_reg <= (cnt_reg == '0) ? cycle_in : cnt_reg - 1'b1;
        end
    end
endmodule : ppgc_partner

// ==== verification/ppgc_tb_top.sv ====
// ppgc_tb_top: bus-level tests of the pulse generator control slice
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ppgc_tb_top;
    logic mclk_in, rst_n_in, hsel_in, hwrite_in, hmastlock_in, port_data_in, trig, tick;
    logic hreadyout_out, hresp_out, borrow, match, load, run, pin, oe, irq;
    logic [11:0] haddr_in;
    logic [1:0] htrans_in;
    logic [2:0] clk_sel, hsize_in;
    logic [31:0] hwdata_in, hrdata_out, rd;
    logic [15:0] cycle_in, duty_in;
    int err_total, check_count, hi, ld;
    ppgc_top u_ppgc_top (
        .*, .hready_in(hreadyout_out), .hw_trigger_input_in(trig), .count_tick_in(tick),
        .borrow_in(borrow), .duty_match_in(match), .counter_load_out(load),
        .counter_run_out(run), .clock_select_out(clk_sel), .pulse_output_pin_out(pin),
        .pin_output_enable_out(oe), .irq_out(irq)
    );
    ppgc_partner u_ppgc_partner (
        .*, .load_in(load), .run_in(run), .trig_out(trig), .tick_out(tick),
        .borrow_out(borrow), .match_out(match)
    );
    initial begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end
    ////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    task automatic wait_until(input logic sel_irq);
        int k;
        k = 0;
        do begin
            if (!sel_irq || irq === 1'b0) @(posedge mclk_in);
            k++;
        end while (((sel_irq && irq !== 1'b1) || (!sel_irq && hreadyout_out !== 1'b1)) && k < 80);
        if (k >= 80) begin
            err_total++;
            wrap_up();
        end
    endtask : wait_until
    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
        hsel_in <= 1'b1;
        haddr_in <= a;
        htrans_in <= ppgc_pkg::HTRANS_NONSEQ;
        hwrite_in <= 1'b1;
        hmastlock_in <= 1'b0;
        wait_until(1'b0);
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        wait_until(1'b0);
    endtask : bus_wr
    task automatic bus_rd(input logic [11:0] a, input logic lk, output logic [31:0] d);
        hsel_in <= 1'b1;
        haddr_in <= a;
        htrans_in <= ppgc_pkg::HTRANS_NONSEQ;
        hwrite_in <= 1'b0;
        hmastlock_in <= lk;
        wait_until(1'b0);
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        wait_until(1'b0);
        d = hrdata_out;
    endtask : bus_rd
    task automatic watch(input int n);
        hi = 0;
        ld = 0;
        repeat (n) begin
            @(posedge mclk_in);
            hi += int'(pin === 1'b1);
            ld += int'(load === 1'b1);
        end
    endtask : watch
    ////////////////////
    initial begin
        rst_n_in = 1'b0;
        hsize_in = 3'h2;
        hsel_in = 1'b0;
        haddr_in = 12'h000;
        htrans_in = 2'h0;
        hwrite_in = 1'b0;
        hmastlock_in = 1'b0;
        hwdata_in = 32'h0;
        port_data_in = 1'b0;
        cycle_in = 16'h0004;
        duty_in = 16'h0002;
        err_total = 0;
        check_count = 0;
        repeat (16) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        @(posedge mclk_in);
        `CHK({oe, irq, run, hresp_out}, 4'h0)
        bus_rd(ppgc_pkg::OFF_CTRL, 1'b0, rd);
        `CHK(rd, {24'h0, ppgc_pkg::CTRL_RESET})
        bus_rd(12'h0C0, 1'b0, rd);
        `CHK(rd, 32'h0)
        $display("test reset done");
        port_data_in <= 1'b1;
        watch(3);
        `CHK(pin, 1'b1)
        bus_wr(ppgc_pkg::OFF_CTRL, 32'h03);
        watch(3);
        `CHK({oe, pin}, 2'h3)
        bus_wr(ppgc_pkg::OFF_CTRL, 32'h02);
        watch(3);
        `CHK(pin, 1'b0)
        $display("test pin done");
        for (int s = 0; s < 4; s++) begin
            bus_wr(ppgc_pkg::OFF_CTRL, 32'h22 | (32'(s) << 2));
            bus_wr(ppgc_pkg::OFF_MODE, 32'hC0);
            watch(3);
            `CHK(irq, 1'(s == 0))
            wait_until(1'b1);
            `CHK(irq, 1'b1)
            bus_rd(ppgc_pkg::OFF_MODE, 1'b0, rd);
            `CHK(rd[7:6], 2'h2)
            bus_wr(ppgc_pkg::OFF_MODE, 32'h00);
            bus_wr(ppgc_pkg::OFF_CTRL, 32'h32 | (32'(s) << 2));
            bus_rd(ppgc_pkg::OFF_CTRL, 1'b0, rd);
            `CHK(rd[4], 1'b1)
            bus_wr(ppgc_pkg::OFF_CTRL, 32'h22 | (32'(s) << 2));
            bus_rd(ppgc_pkg::OFF_CTRL, 1'b0, rd);
            `CHK(rd[4], 1'b0)
        end
        $display("test sources done");
        bus_rd(ppgc_pkg::OFF_CTRL, 1'b1, rd);
        `CHK(rd[4], 1'b1)
        bus_wr(ppgc_pkg::OFF_CTRL, 32'h02);
        bus_wr(ppgc_pkg::OFF_MODE, 32'hC0);
        watch(4);
        `CHK(irq, 1'b0)
        bus_wr(ppgc_pkg::OFF_CTRL, 32'h32);
        watch(2);
        `CHK(irq, 1'b1)
        $display("test flag done");
        watch(24);
        `CHK(1'(hi > 0), 1'b1)
        bus_wr(ppgc_pkg::OFF_MODE, 32'h8F);
        watch(3);
        `CHK(clk_sel, 3'h7)
        watch(24);
        `CHK(hi, 0)
        bus_wr(ppgc_pkg::OFF_CTRL, 32'h33);
        watch(3);
        watch(24);
        `CHK(hi, 24)
        $display("test mask done");
        bus_wr(ppgc_pkg::OFF_MODE, 32'h00);
        bus_wr(ppgc_pkg::OFF_CTRL, 32'h02);
        bus_wr(ppgc_pkg::OFF_MODE, 32'h80);
        u_ppgc_partner.drive_trigger(1'b1);
        watch(10);
        `CHK(ld, 0)
        u_ppgc_partner.drive_trigger(1'b0);
        bus_wr(ppgc_pkg::OFF_CTRL, 32'h42);
        u_ppgc_partner.drive_trigger(1'b1);
        watch(10);
        `CHK(ld, 1)
        u_ppgc_partner.drive_trigger(1'b0);
        watch(8);
        `CHK(run, 1'b1)
        bus_wr(ppgc_pkg::OFF_CTRL, 32'hC2);
        u_ppgc_partner.drive_trigger(1'b1);
        watch(8);
        u_ppgc_partner.drive_trigger(1'b0);
        watch(8);
        `CHK(run, 1'b0)
        $display("test trigger done");
        bus_wr(ppgc_pkg::OFF_MODE, 32'h00);
        cycle_in <= 16'h0003;
        duty_in <= 16'h0003;
        bus_wr(ppgc_pkg::OFF_CTRL, 32'h2A);
        bus_wr(ppgc_pkg::OFF_MODE, 32'hC0);
        wait_until(1'b1);
        `CHK(irq, 1'b1)
        bus_wr(ppgc_pkg::OFF_CTRL, 32'h2A);
        watch(40);
        `CHK({irq, 1'(hi == 40)}, 2'h1)
        bus_wr(ppgc_pkg::OFF_MODE, 32'hD0);
        watch(8);
        `CHK(1'(hi < 8), 1'b1)
        bus_wr(ppgc_pkg::OFF_MODE, 32'h00);
        duty_in <= 16'h0005;
        bus_wr(ppgc_pkg::OFF_CTRL, 32'h2A);
        bus_wr(ppgc_pkg::OFF_MODE, 32'hC0);
        watch(40);
        `CHK({irq, 1'(hi == 0)}, 2'h1)
        bus_wr(ppgc_pkg::OFF_MODE, 32'h00);
        duty_in <= 16'h0000;
        bus_wr(ppgc_pkg::OFF_MODE, 32'hC0);
        watch(40);
        `CHK(hi, 0)
        $display("test duty done");
        wrap_up();
    end
endmodule : ppgc_tb_top
